// File: logic/mpc_pin_cell.sv
// decode of one pin's configuration and data bits
`timescale 1ns/1ps
`default_nettype none
module mpc_pin_cell (
    // register bits
    input wire logic cfg,
    input wire logic dat,
    // pad controls
    output logic oe,
    output logic out,
    output logic pu
);
    // 00 hi-z, 01 pull-up, 10 drive low, 11 drive high
    assign oe = cfg; // see RL1
    assign out = cfg & dat; // see RL1
    assign pu = ~cfg & dat; // see RL1
endmodule
`default_nettype wire

// File: logic/mpc_pkg.sv
// shared constants for the port configuration block
package mpc_pkg;
    // port geometry
    localparam int PORT_W = 8;
    localparam int NUM_GEN_PORTS = 3;
    localparam int WAKE_PORT = 0;
    // register map, byte addresses
    localparam logic [7:0] PORT_STRIDE = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h01;
    localparam logic [7:0] OFS_PINS = 8'h02;
    localparam logic [7:0] MIXED_BASE = 8'h0C;
    // reset values
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    // mixed port special bit positions
    localparam int MX_SUP = 1;
    localparam int MX_SDO = 4;
    localparam int MX_SCK = 5;
    localparam int MX_IN6 = 6;
    localparam int MX_OSC = 7;
    localparam int MX_ALT_PHASE = 6;
    localparam int MX_DLY_EN = 7;
    localparam int MX_IDLE = 6;
    localparam int MX_HALT = 7;
    // oscillator option codes
    localparam logic [1:0] OSC_EXT = 2'h0;
    localparam logic [1:0] OSC_RC = 2'h1;
    localparam int OSC_XTAL_BIT = 1;
    // start-up delay length in cycles
    localparam int DLY_W = 16;
    localparam logic [15:0] STARTUP_DLY_CYC = 16'h0100;
    // power mode states
    typedef enum logic [1:0] {
        MPC_RUN = 2'b00,
        MPC_IDLE = 2'b01,
        MPC_HALT = 2'b10,
        MPC_DLY = 2'b11
    } mpc_pmode_t;
endpackage

// File: logic/mpc_port_cfg.sv
// microcontroller port configuration logic, general and mixed ports
// Notes on behaviour
// RL1 - configuration and data bits select hi-z, pull-up, drive low or drive high
// RL2 - each port has configuration, output data and pin level locations
// RL3 - unbonded port bits read back whatever the floating pad gives
// RL4 - software sets unbonded bits as outputs to save supply current
// RL5 - mixed pin 6 is always a hi-z input
// RL6 - supervisor option drives mixed pin 1 with pull-up, its bits ignored
// RL7 - without supervisor option mixed pin 1 is ordinary I/O
// RL8 - crystal option makes mixed pin 7 the oscillator drive output
// RL9 - otherwise pin 7 is hi-z input whose rising edge ends halt
// RL10 - mixed data bits 6 and 7 read as zero
// RL11 - writing one to mixed data bit 7 enters halt
// RL12 - writing one to mixed data bit 6 enters idle
// RL13 - mixed configuration bit 6 selects alternate shift clock phase
// RL14 - mixed configuration bit 7 enables start-up delay after halt with R/C
// RL15 - mixed pins carry interrupt, capture, timer, serial out, clock, in
// RL16 - wake-up port pins are Schmitt inputs usable as wake-up sources
// RL17 - external interrupt and timer levels last at least one cycle
// RL18 - software leaves registers of an unbonded port unused
// RL19 - pin level locations return synchronised levels regardless of setup
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module mpc_port_cfg #(
    parameter int NP = mpc_pkg::NUM_GEN_PORTS,
    parameter logic [15:0] DLY_CYC = mpc_pkg::STARTUP_DLY_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // factory option straps
    input wire logic supervisor_enable,
    input wire logic [1:0] osc_option,
    // general port pads
    input wire logic [NP*8-1:0] gen_pin_in,
    output logic [NP*8-1:0] gen_pin_out,
    output logic [NP*8-1:0] gen_pin_oe,
    output logic [NP*8-1:0] gen_pin_pullup,
    // mixed port pads
    input wire logic [7:0] mix_pin_in,
    output logic [7:0] mix_pin_out,
    output logic [7:0] mix_pin_oe,
    output logic [7:0] mix_pin_pullup,
    // alternate function sources
    input wire logic supervisor_out_pin,
    input wire logic osc_drive_output,
    input wire logic serial_data_out,
    input wire logic serial_shift_clock_out,
    input wire logic [1:0] serial_drive_en,
    // alternate function inputs seen by peripherals
    output logic external_interrupt_input,
    output logic timer_capture_input,
    output logic timer_io_pin,
    output logic serial_shift_clock,
    output logic serial_data_in,
    output logic [7:0] wake_pin_edge,
    // power control
    input wire logic halt_wake_req,
    input wire logic idle_wake_req,
    output logic halt_mode,
    output logic idle_mode,
    output logic startup_delay_enable,
    output logic alt_shift_clock_phase
);
    localparam int NB = NP * 8;

    typedef struct packed {
        logic opt_ok;
        logic sup_en;
        logic [1:0] osc_opt;
        logic [NP-1:0][7:0] cfg;
        logic [NP-1:0][7:0] dat;
        logic [7:0] mcfg;
        logic [5:0] mdat;
        mpc_pkg::mpc_pmode_t pm;
        logic [mpc_pkg::DLY_W-1:0] dly_cnt;
        logic halt;
        logic idle;
        logic dly;
        logic g7_prev;
        logic [7:0] wake_prev;
        logic [7:0] wake_edge;
        logic [7:0] rdata;
        logic [NB-1:0] g_out;
        logic [NB-1:0] g_oe;
        logic [NB-1:0] g_pu;
        logic [7:0] m_out;
        logic [7:0] m_oe;
        logic [7:0] m_pu;
    } mpc_state_t;

    mpc_state_t s, n;
    logic [NB+7:0] pin_sync;
    logic [NB-1:0] gc_oe, gc_out, gc_pu;
    logic [7:0] mc_oe, mc_out, mc_pu;
    logic [7:0] mix_lvl;
    logic xtal, rc_opt, g7_rise;

    // address match against a register location
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] loc);
        addr_hit = (a == loc);
    endfunction

    // synchronised pad levels
    mpc_sync #(.W(NB + 8)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d({mix_pin_in, gen_pin_in}),
        .q(pin_sync)
    );

    // per-pin decode for general and mixed ports
    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : g_gen
            mpc_pin_cell u_cell (
                .cfg(s.cfg[gi/8][gi%8]),
                .dat(s.dat[gi/8][gi%8]),
                .oe(gc_oe[gi]),
                .out(gc_out[gi]),
                .pu(gc_pu[gi])
            );
        end
        for (gi = 0; gi < 6; gi++) begin : g_mix
            mpc_pin_cell u_cell (
                .cfg(s.mcfg[gi]),
                .dat(s.mdat[gi]),
                .oe(mc_oe[gi]),
                .out(mc_out[gi]),
                .pu(mc_pu[gi])
            );
        end
    endgenerate
    // pins 6 and 7 never use the plain decode
    assign mc_oe[7:6] = 2'h0; // see RL5
    assign mc_out[7:6] = 2'h0;
    assign mc_pu[7:6] = 2'h0;

    // option and edge decode
    assign mix_lvl = pin_sync[NB +: 8];
    assign xtal = s.osc_opt[mpc_pkg::OSC_XTAL_BIT];
    assign rc_opt = (s.osc_opt == mpc_pkg::OSC_RC);
    assign g7_rise = ~xtal & mix_lvl[mpc_pkg::MX_OSC] & ~s.g7_prev; // see RL9

    // next-state logic
    always_comb begin
        n = s;
        // straps caught once after reset release
        if (!s.opt_ok) begin
            n.opt_ok = 1'b1;
            n.sup_en = supervisor_enable;
            n.osc_opt = osc_option;
        end
        // register writes
        if (reg_wr) begin
            for (int p = 0; p < NP; p++) begin
                if (addr_hit(reg_addr, 8'(p * mpc_pkg::PORT_STRIDE) + mpc_pkg::OFS_DATA)) begin
                    n.dat[p] = reg_wdata; // see RL2
                end
                if (addr_hit(reg_addr, 8'(p * mpc_pkg::PORT_STRIDE) + mpc_pkg::OFS_CFG)) begin
                    n.cfg[p] = reg_wdata; // see RL2
                end
            end
            if (addr_hit(reg_addr, mpc_pkg::MIXED_BASE + mpc_pkg::OFS_CFG)) begin
                n.mcfg = reg_wdata;
            end
            if (addr_hit(reg_addr, mpc_pkg::MIXED_BASE + mpc_pkg::OFS_DATA)) begin
                n.mdat = reg_wdata[5:0];
            end
        end
        // power mode sequencing
        case (s.pm)
            mpc_pkg::MPC_RUN: begin
                if (reg_wr && addr_hit(reg_addr, mpc_pkg::MIXED_BASE + mpc_pkg::OFS_DATA)) begin
                    if (reg_wdata[mpc_pkg::MX_HALT]) begin
                        n.pm = mpc_pkg::MPC_HALT; // see RL11
                    end else if (reg_wdata[mpc_pkg::MX_IDLE]) begin
                        n.pm = mpc_pkg::MPC_IDLE; // see RL12
                    end
                end
            end
            mpc_pkg::MPC_IDLE: begin
                if (idle_wake_req) begin
                    n.pm = mpc_pkg::MPC_RUN;
                end
            end
            mpc_pkg::MPC_HALT: begin
                if (g7_rise || halt_wake_req) begin // see RL9
                    n.dly_cnt = '0;
                    if (s.mcfg[mpc_pkg::MX_DLY_EN] && rc_opt) begin
                        n.pm = mpc_pkg::MPC_DLY; // see RL14
                    end else begin
                        n.pm = mpc_pkg::MPC_RUN;
                    end
                end
            end
            mpc_pkg::MPC_DLY: begin
                n.dly_cnt = s.dly_cnt + 1'b1;
                if (s.dly_cnt == DLY_CYC - 1'b1) begin
                    n.pm = mpc_pkg::MPC_RUN;
                end
            end
            default: begin
                n.pm = mpc_pkg::MPC_RUN;
            end
        endcase
        n.halt = (n.pm == mpc_pkg::MPC_HALT);
        n.idle = (n.pm == mpc_pkg::MPC_IDLE);
        n.dly = (n.pm == mpc_pkg::MPC_DLY);
        // edge tracking for wake-up sources
        n.g7_prev = mix_lvl[mpc_pkg::MX_OSC];
        n.wake_prev = pin_sync[mpc_pkg::WAKE_PORT*8 +: 8];
        n.wake_edge = pin_sync[mpc_pkg::WAKE_PORT*8 +: 8] ^ s.wake_prev; // see RL16
        // read data, one cycle after the strobe
        n.rdata = 8'h00;
        if (reg_rd) begin
            for (int p = 0; p < NP; p++) begin
                if (addr_hit(reg_addr, 8'(p * mpc_pkg::PORT_STRIDE) + mpc_pkg::OFS_DATA)) begin
                    n.rdata = s.dat[p];
                end
                if (addr_hit(reg_addr, 8'(p * mpc_pkg::PORT_STRIDE) + mpc_pkg::OFS_CFG)) begin
                    n.rdata = s.cfg[p];
                end
                if (addr_hit(reg_addr, 8'(p * mpc_pkg::PORT_STRIDE) + mpc_pkg::OFS_PINS)) begin
                    n.rdata = pin_sync[p*8 +: 8]; // see RL19, see RL3
                end
            end
            if (addr_hit(reg_addr, mpc_pkg::MIXED_BASE + mpc_pkg::OFS_DATA)) begin
                n.rdata = {2'h0, s.mdat}; // see RL10
            end
            if (addr_hit(reg_addr, mpc_pkg::MIXED_BASE + mpc_pkg::OFS_CFG)) begin
                n.rdata = s.mcfg;
            end
            if (addr_hit(reg_addr, mpc_pkg::MIXED_BASE + mpc_pkg::OFS_PINS)) begin
                n.rdata = mix_lvl; // see RL19
            end
        end
        // general pad controls
        n.g_out = gc_out; // see RL1
        n.g_oe = gc_oe;
        n.g_pu = gc_pu;
        // mixed pad controls with special pins
        n.m_out = mc_out; // see RL7
        n.m_oe = mc_oe;
        n.m_pu = mc_pu;
        if (s.mcfg[mpc_pkg::MX_SDO] && serial_drive_en[0]) begin
            n.m_out[mpc_pkg::MX_SDO] = serial_data_out; // see RL15
        end
        if (s.mcfg[mpc_pkg::MX_SCK] && serial_drive_en[1]) begin
            n.m_out[mpc_pkg::MX_SCK] = serial_shift_clock_out; // see RL15
        end
        if (s.sup_en) begin
            n.m_oe[mpc_pkg::MX_SUP] = ~supervisor_out_pin; // see RL6
            n.m_out[mpc_pkg::MX_SUP] = 1'b0;
            n.m_pu[mpc_pkg::MX_SUP] = 1'b1;
        end
        if (xtal) begin
            n.m_oe[mpc_pkg::MX_OSC] = 1'b1; // see RL8
            n.m_out[mpc_pkg::MX_OSC] = osc_drive_output;
        end
    end

    // state registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.cfg <= {NP{mpc_pkg::CFG_RST}};
            s.dat <= {NP{mpc_pkg::DATA_RST}};
            s.mcfg <= mpc_pkg::CFG_RST;
            s.mdat <= mpc_pkg::DATA_RST[5:0];
            s.pm <= mpc_pkg::MPC_RUN;
        end else begin
            s <= n;
        end
    end

    // outputs straight from state
    assign reg_rdata = s.rdata;
    assign gen_pin_out = s.g_out;
    assign gen_pin_oe = s.g_oe;
    assign gen_pin_pullup = s.g_pu;
    assign mix_pin_out = s.m_out;
    assign mix_pin_oe = s.m_oe;
    assign mix_pin_pullup = s.m_pu;
    assign external_interrupt_input = mix_lvl[0]; // see RL15, see RL17
    assign timer_capture_input = mix_lvl[2];
    assign timer_io_pin = mix_lvl[3];
    assign serial_shift_clock = mix_lvl[mpc_pkg::MX_SCK];
    assign serial_data_in = mix_lvl[mpc_pkg::MX_IN6];
    assign wake_pin_edge = s.wake_edge;
    assign halt_mode = s.halt;
    assign idle_mode = s.idle;
    assign startup_delay_enable = s.dly;
    assign alt_shift_clock_phase = s.mcfg[mpc_pkg::MX_ALT_PHASE]; // see RL13

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence halt_write;
        s.pm == mpc_pkg::MPC_RUN && reg_wr &&
            reg_addr == mpc_pkg::MIXED_BASE && reg_wdata[7];
    endsequence
    sequence halt_held;
        halt_mode ##1 halt_mode;
    endsequence

    chk_gen_decode: assert property (##1 gen_pin_pullup == ($past(~s.cfg) & $past(s.dat)))
        else $error("general pull-up decode wrong"); // see RL1
    chk_pin6_input: assert property (##1 !mix_pin_oe[6] && !mix_pin_pullup[6])
        else $error("pin 6 not hi-z"); // see RL5
    chk_halt_entry: assert property (halt_write |-> ##1 halt_mode)
        else $error("halt not entered"); // see RL11
    chk_halt_stays: assert property (halt_mode && !halt_wake_req && !g7_rise |=> halt_mode)
        else $error("halt left without wake"); // see RL9
    chk_idle_entry: assert property (s.pm == mpc_pkg::MPC_RUN && reg_wr &&
        reg_addr == mpc_pkg::MIXED_BASE && reg_wdata[7:6] == 2'b01 |=> idle_mode)
        else $error("idle not entered"); // see RL12
    chk_mix_rdzero: assert property (reg_rd && reg_addr == mpc_pkg::MIXED_BASE |=>
        reg_rdata[7:6] == 2'b00)
        else $error("mixed data bits 7:6 not zero"); // see RL10
    chk_xtal_drive: assert property (s.opt_ok && xtal |=> mix_pin_oe[7])
        else $error("oscillator pin not driven"); // see RL8
    chk_sup_pin: assert property (s.opt_ok && s.sup_en |=> mix_pin_pullup[1] && !mix_pin_out[1])
        else $error("supervisor pin setup wrong"); // see RL6
    chk_pin_read: assert property (reg_rd && reg_addr == mpc_pkg::OFS_PINS |=>
        reg_rdata == $past(pin_sync[7:0]))
        else $error("pin level read wrong"); // see RL19
    chk_halt_seq: assert property (halt_write ##1 halt_held |-> !idle_mode)
        else $error("idle during halt"); // see RL11
endmodule
`default_nettype wire

// File: logic/mpc_sync.sv
// two-stage level synchroniser for pad inputs
`timescale 1ns/1ps
`default_nettype none
module mpc_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mpc_sync_t;

    mpc_sync_t s, n;

    // first stage feeds only the second
    always_comb begin
        n = s;
        n.s1 = d;
        n.s2 = s.s1;
    end

    // state registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign q = s.s2;
endmodule
`default_nettype wire

// File: sim/mpc_pad_model.sv
// pad model: external circuitry hanging on the package pins
`timescale 1ns/1ps
`default_nettype none
module mpc_pad_model #(
    parameter int W = 8
) (
    // clock
    input wire logic clk,
    // device pad controls
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] pull_en,
    // external sources
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    // resolved pad level
    output logic [W-1:0] level
);
    logic [W-1:0] float_r = '0;
    // floating pad flips every cycle so a stale level never passes
    always @(posedge clk) begin
        float_r <= ~float_r;
    end
    // device drive first, then the outside source, then the weak pull-up
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe[i]) level[i] = out[i];
            else if (ext_en[i]) level[i] = ext_val[i];
            else if (pull_en[i]) level[i] = 1'b1;
            else level[i] = float_r[i];
        end
    end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the port configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic sup_en = 1'b1;
    logic [1:0] osc_opt = mpc_pkg::OSC_RC;
    logic [23:0] gen_in, gen_out, gen_oe, gen_pu;
    logic [23:0] gen_ext_en = 24'hDDDDDD;
    logic [23:0] gen_ext_val = 24'h101010;
    logic [7:0] mix_in, mix_out, mix_oe, mix_pu;
    logic [7:0] mix_ext_en = 8'hFF;
    logic [7:0] mix_ext_val = 8'h00;
    logic sup_out = 1'b0;
    logic osc_drv = 1'b0;
    logic sdo = 1'b0;
    logic sck_o = 1'b0;
    logic [1:0] sdrv = 2'h0;
    logic ext_int, cap, tio, sck, sdi;
    logic [7:0] wake_edge;
    logic halt_req = 1'b0;
    logic idle_req = 1'b0;
    logic halt_mode, idle_mode, dly_en, alt_ph;
    logic [7:0] pat;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // device under test, start-up delay shortened to 4 cycles
    mpc_port_cfg #(.NP(3), .DLY_CYC(16'h0004)) uut (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .supervisor_enable(sup_en), .osc_option(osc_opt),
        .gen_pin_in(gen_in), .gen_pin_out(gen_out), .gen_pin_oe(gen_oe),
        .gen_pin_pullup(gen_pu), .mix_pin_in(mix_in), .mix_pin_out(mix_out),
        .mix_pin_oe(mix_oe), .mix_pin_pullup(mix_pu), .supervisor_out_pin(sup_out),
        .osc_drive_output(osc_drv), .serial_data_out(sdo),
        .serial_shift_clock_out(sck_o), .serial_drive_en(sdrv),
        .external_interrupt_input(ext_int), .timer_capture_input(cap),
        .timer_io_pin(tio), .serial_shift_clock(sck), .serial_data_in(sdi),
        .wake_pin_edge(wake_edge), .halt_wake_req(halt_req), .idle_wake_req(idle_req),
        .halt_mode(halt_mode), .idle_mode(idle_mode),
        .startup_delay_enable(dly_en), .alt_shift_clock_phase(alt_ph)
    );

    // far-side pads of the general and mixed ports
    mpc_pad_model #(.W(24)) gen_pads (.clk(clk), .oe(gen_oe), .out(gen_out),
        .pull_en(gen_pu), .ext_en(gen_ext_en), .ext_val(gen_ext_val), .level(gen_in));
    mpc_pad_model #(.W(8)) mix_pads (.clk(clk), .oe(mix_oe), .out(mix_out),
        .pull_en(mix_pu), .ext_en(mix_ext_en), .ext_val(mix_ext_val), .level(mix_in));

    // verdict and end of run
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fail_count++;
            test_done;
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, reg_rdata, exp);
    endtask

    task automatic do_reset(input logic s, input logic [1:0] o);
        @(posedge clk);
        rst_b <= 1'b0;
        sup_en <= s;
        osc_opt <= o;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        tick(2);
    endtask

    // main sequence; only the three general ports and the mixed port are used
    initial begin
        do_reset(1'b1, mpc_pkg::OSC_RC);
        chk("gen_oe", gen_oe[7:0], 8'h00);
        rdc(8'h01, 8'h00, "cfg0 reset");
        rdc(8'h0C, 8'h00, "mix data reset");
        $display("test reset done");
        // four decodes on every general port; bits 0 and 4 fed from outside
        for (int p = 0; p < 3; p++) begin
            wr(8'(p * 4 + 1), 8'hCC);
            wr(8'(p * 4), 8'hAA);
            tick(3);
            chk("oe", gen_oe[p*8+:8], 8'hCC);
            chk("pullup", gen_pu[p*8+:8], 8'h22);
            chk("out", gen_out[p*8+:8] & gen_oe[p*8+:8], 8'h88);
            rdc(8'(p * 4 + 2), 8'hBA, "pins");
            wr(8'(p * 4 + 2), 8'h55);
            rdc(8'(p * 4), 8'hAA, "data");
            rdc(8'(p * 4 + 1), 8'hCC, "cfg");
        end
        wr(8'h03, 8'hFF);
        rdc(8'h03, 8'h00, "unmapped");
        $display("test decode done");
        // wake-up port pin 0 rises from outside
        gen_ext_val[0] <= 1'b1;
        n = 0;
        while (wake_edge[0] !== 1'b1 && n < 6) begin
            tick(1);
            n++;
        end
        chk("wake edge", wake_edge[0], 1'b1);
        // mixed port with supervisor and R/C straps
        wr(8'h0D, 8'hFF);
        wr(8'h0C, 8'h3F);
        tick(2);
        chk("pin6 oe", mix_oe[6], 1'b0);
        chk("pin7 oe", mix_oe[7], 1'b0);
        chk("pin1 oe", mix_oe[1], 1'b1);
        chk("pin1 out", mix_out[1], 1'b0);
        chk("alt phase", alt_ph, 1'b1);
        @(posedge clk);
        sup_out <= 1'b1;
        tick(2);
        chk("pin1 rel", mix_oe[1], 1'b0);
        chk("pin1 pu", mix_pu[1], 1'b1);
        rdc(8'h0D, 8'hFF, "mix cfg");
        rdc(8'h0C, 8'h3F, "mix data");
        $display("test mixed pins done");
        // alternate inputs, each level held well over one cycle
        wr(8'h0D, 8'hC0);
        wr(8'h0C, 8'h00);
        for (int k = 0; k < 2; k++) begin
            pat = (k == 0) ? 8'h6D : 8'h48;
            mix_ext_val <= pat;
            tick(4);
            chk("alt in", {sdi, sck, tio, cap, ext_int},
                {pat[6], pat[5], pat[3], pat[2], pat[0]});
        end
        wr(8'h0D, 8'hF0);
        sdrv <= 2'h3;
        sdo <= 1'b1;
        tick(3);
        chk("serial out", mix_out[5:4] & mix_oe[5:4], 8'h01);
        $display("test alternate done");
        // halt, then wake with start-up delay
        wr(8'h0C, 8'hC5);
        tick(1);
        chk("halt", {idle_mode, halt_mode}, 8'h01);
        rdc(8'h0C, 8'h05, "mode bits");
        @(posedge clk);
        halt_req <= 1'b1;
        @(posedge clk);
        halt_req <= 1'b0;
        n = 0;
        while (dly_en !== 1'b1 && n < 8) begin
            tick(1);
            n++;
        end
        // the cycle already seen high counts as the first
        n = 1;
        while (dly_en === 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk("delay len", 8'(n), 8'h04);
        chk("halt end", halt_mode, 1'b0);
        // idle entry and exit
        wr(8'h0C, 8'h40);
        tick(1);
        chk("idle", {idle_mode, halt_mode}, 8'h02);
        @(posedge clk);
        idle_req <= 1'b1;
        @(posedge clk);
        idle_req <= 1'b0;
        tick(2);
        chk("idle end", idle_mode, 1'b0);
        // halt ended by a rising edge on pin 7
        mix_ext_val <= 8'h00;
        wr(8'h0D, 8'h00);
        wr(8'h0C, 8'h80);
        tick(1);
        chk("halt2", halt_mode, 1'b1);
        mix_ext_val[7] <= 1'b1;
        n = 0;
        while (halt_mode !== 1'b0 && n < 8) begin
            tick(1);
            n++;
        end
        chk("pin7 wake", halt_mode, 1'b0);
        $display("test power done");
        // plain pin 1 and crystal drive on pin 7
        do_reset(1'b0, 2'h2);
        @(posedge clk);
        sup_out <= 1'b0;
        wr(8'h0D, 8'h02);
        wr(8'h0C, 8'h02);
        tick(2);
        chk("pin1 gpio", {mix_pu[1], mix_oe[1], mix_out[1]}, 8'h03);
        @(posedge clk);
        osc_drv <= 1'b1;
        tick(3);
        chk("osc hi", {mix_oe[7], mix_out[7]}, 8'h03);
        @(posedge clk);
        osc_drv <= 1'b0;
        tick(3);
        chk("osc lo", {mix_oe[7], mix_out[7]}, 8'h02);
        // upper half of port 2 treated as unbonded, set as outputs
        wr(8'h09, 8'hF0);
        tick(2);
        chk("unbonded oe", gen_oe[23:16], 8'hF0);
        $display("test options done");
        test_done;
    end
endmodule
`default_nettype wire
